/* hdl/plc_pkg.sv */
package plc_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SEL    = 8'h04;
  localparam logic [7:0] OFS_GATE   = 8'h08;
  localparam logic [7:0] OFS_GPOL   = 8'h0c;
  localparam logic [7:0] OFS_SWBITS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_POL_BIT  = 7;
  localparam int CTRL_OE_BIT   = 8;

  // Stride of the four select codes and the four gate enable bytes
  localparam int SEL_STRIDE  = 8;
  localparam int GATE_STRIDE = 8;

  // Status register fields
  localparam int STAT_OUT_BIT   = 0;
  localparam int STAT_LINES_LSB = 4;

  // Pool position carrying the software register bit
  localparam int SWBIT_POOL_IDX = 7;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SEL_RST    = 32'h0000_0000;
  localparam logic [31:0] GATE_RST   = 32'h0000_0000;
  localparam logic [3:0]  GPOL_RST   = 4'h0;
  localparam logic [3:0]  SWBITS_RST = 4'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Function options
  typedef enum logic [2:0] {
    PLC_F_ANDOR  = 3'h0,
    PLC_F_ORXOR  = 3'h1,
    PLC_F_AND4   = 3'h2,
    PLC_F_SRLAT  = 3'h3,
    PLC_F_DFF_SR = 3'h4,
    PLC_F_DFF_R  = 3'h5,
    PLC_F_JK_R   = 3'h6,
    PLC_F_DLAT   = 3'h7
  } plc_func_t;

  // Bus channel states, Gray along idle to answer
  typedef enum logic [1:0] {
    PLC_W_COLLECT = 2'b00,
    PLC_W_RESP    = 2'b01
  } plc_wr_state_t;

  typedef enum logic [1:0] {
    PLC_R_IDLE = 2'b00,
    PLC_R_DATA = 2'b01
  } plc_rd_state_t;

endpackage : plc_pkg

/* hdl/plc_func_if.sv */
`timescale 1ns/1ps
interface plc_func_if;
  logic [3:0]         lines;
  plc_pkg::plc_func_t mode;
  logic               run;
  logic               result;

  modport top  (output lines, output mode, output run, input result);
  modport func (input lines, input mode, input run, output result);
endinterface : plc_func_if

/* hdl/plc_func.sv */
`timescale 1ns/1ps
module plc_func (
  input wire logic   clock,
  input wire logic   reset_n,
  input wire logic   clock_en,
  plc_func_if.func   fbus
);
  logic g0, g1, g2, g3;
  logic state_reg;
  logic clk_prev_reg;
  logic rise;
  assign g0 = fbus.lines[0];
  assign g1 = fbus.lines[1];
  assign g2 = fbus.lines[2];
  assign g3 = fbus.lines[3];
  // Edge seen on line 0, the clock of the edge-clocked options
  assign rise = g0 & ~clk_prev_reg;

  // Previous level of the clock line
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_reg <= 1'b0;
    end else if (clock_en) begin
      clk_prev_reg <= g0;
    end
  end

  // Stored bit of the latch and flip-flop options
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= 1'b0;
    end else if (clock_en && fbus.run) begin
      case (fbus.mode)
        plc_pkg::PLC_F_SRLAT: begin
          if (g0 | g1) state_reg <= 1'b1;
          else if (g2 | g3) state_reg <= 1'b0;
        end
        plc_pkg::PLC_F_DFF_SR: begin
          if (g2) state_reg <= 1'b0;
          else if (g3) state_reg <= 1'b1;
          else if (rise) state_reg <= g1;
        end
        plc_pkg::PLC_F_DFF_R: begin
          if (g2) state_reg <= 1'b0;
          else if (rise) state_reg <= g1;
        end
        plc_pkg::PLC_F_JK_R: begin
          if (g2) state_reg <= 1'b0;
          else if (rise) state_reg <= (g1 & ~state_reg) | (~g3 & state_reg);
        end
        plc_pkg::PLC_F_DLAT: begin
          if (g2) state_reg <= 1'b0;
          else if (g3) state_reg <= 1'b1;
          else if (g0) state_reg <= g1;
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  // Single output of the chosen option; set and reset act at once, except in PLC_F_SRLAT
  always_comb begin
    case (fbus.mode)
      plc_pkg::PLC_F_ANDOR:  fbus.result = (g0 & g1) | (g2 & g3);
      plc_pkg::PLC_F_ORXOR:  fbus.result = (g0 | g1) ^ (g2 | g3);
      plc_pkg::PLC_F_AND4:   fbus.result = g0 & g1 & g2 & g3;
      plc_pkg::PLC_F_SRLAT:  fbus.result = state_reg;
      plc_pkg::PLC_F_DFF_SR: fbus.result = g2 ? 1'b0 : (g3 | state_reg);
      plc_pkg::PLC_F_DFF_R:  fbus.result = ~g2 & state_reg;
      plc_pkg::PLC_F_JK_R:   fbus.result = ~g2 & state_reg;
      plc_pkg::PLC_F_DLAT:   fbus.result =
          g2 ? 1'b0 : (g3 ? 1'b1 : (g0 ? g1 : state_reg));
      default:               fbus.result = 1'b0;
    endcase
  end
endmodule : plc_func

/* hdl/plc_top.sv */
`timescale 1ns/1ps
module plc_top (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clock_en,
  input  wire logic [31:0] pool_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cell_out,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             out_rise,
  output logic             out_fall
);

  // Software-visible configuration
  logic [31:0] ctrl_reg;
  logic [31:0] sel_reg;
  logic [31:0] gate_reg;
  logic [3:0]  gpol_reg;
  logic [3:0]  swbits_reg;

  // Bus slave state
  plc_pkg::plc_wr_state_t wr_state_reg;
  plc_pkg::plc_rd_state_t rd_state_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;

  // Datapath
  logic [31:0] pool;
  logic [3:0]  picked;
  logic [3:0]  lines;
  logic        out_next;

  // Lines, mode and enable go down; the single result comes back
  plc_func_if fbus ();

  // Pick one pool bit by a five-bit code
  function automatic logic pick(input logic [31:0] src,
                                input logic [4:0]  code);
    pick = src[code];
  endfunction : pick

  // One gate: AND of enabled true/inverted inputs, then polarity
  function automatic logic gate(input logic [3:0] ins,
                                input logic [7:0] en,
                                input logic       inv);
    logic acc;
    logic any;
    acc = 1'b1;
    any = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (en[2*k])   acc = acc & ins[k];
      if (en[2*k+1]) acc = acc & ~ins[k];
      any = any | en[2*k] | en[2*k+1];
    end
    gate = (any & acc) ^ inv;
  endfunction : gate

  // Byte-lane merge of a write into a 32-bit register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    merge = res;
  endfunction : merge

  // Unmapped offsets answer with an error rather than alias a register
  // Known register offsets
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == plc_pkg::OFS_CTRL) || (a == plc_pkg::OFS_SEL) ||
             (a == plc_pkg::OFS_GATE) || (a == plc_pkg::OFS_GPOL) ||
             (a == plc_pkg::OFS_SWBITS) || (a == plc_pkg::OFS_STATUS);
  endfunction : mapped

  // Candidate pool; the spare slot carries a software bit
  // Slot 7 is reserved in the pool, so software may drive a level there
  always_comb begin
    pool = pool_in;
    pool[plc_pkg::SWBIT_POOL_IDX] = swbits_reg[0];
  end

  // Selection then gating, purely combinational so no software latency
  // Pool glitches reach the lines; only the output flop filters them
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      picked[m] = pick(pool,
                       sel_reg[plc_pkg::SEL_STRIDE*m +: 5]);
    end
    for (int g = 0; g < 4; g++) begin
      lines[g] = gate(picked,
                      gate_reg[plc_pkg::GATE_STRIDE*g +: 8],
                      gpol_reg[g]);
    end
  end

  // Hand the lines to the function stage
  assign fbus.lines = lines;
  assign fbus.mode  = plc_pkg::plc_func_t'(
      ctrl_reg[plc_pkg::CTRL_MODE_LSB +: 3]);
  assign fbus.run   = ctrl_reg[plc_pkg::CTRL_EN_BIT];

  plc_func u_func (
    .clock    (clock),
    .reset_n  (reset_n),
    .clock_en (clock_en),
    .fbus     (fbus.func)
  );

  // Polarity stage; a disabled cell holds its output low
  assign out_next = ctrl_reg[plc_pkg::CTRL_EN_BIT] &
                    (fbus.result ^ ctrl_reg[plc_pkg::CTRL_POL_BIT]);

  // Registered output, shared by peripherals and the pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cell_out <= 1'b0;
      pin_out  <= 1'b0;
      pin_oe   <= 1'b0;
      out_rise <= 1'b0;
      out_fall <= 1'b0;
    end else if (clock_en) begin
      cell_out <= out_next;
      pin_out  <= out_next;
      pin_oe   <= ctrl_reg[plc_pkg::CTRL_OE_BIT] &
                  ctrl_reg[plc_pkg::CTRL_EN_BIT];
      // Edges include those caused by flipping the polarity
      out_rise <= out_next & ~cell_out;
      out_fall <= ~out_next & cell_out;
    end
  end

  // Channel handshakes
  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign do_write = (wr_state_reg == plc_pkg::PLC_W_COLLECT) &
                    aw_got_reg & w_got_reg;

  // Write side: address and data in either order, then the response
  // Nothing is written until both halves are in, so a lone address is inert
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_state_reg  <= plc_pkg::PLC_W_COLLECT;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      waddr_reg     <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= plc_pkg::RESP_OKAY;
    end else if (clock_en) begin
      case (wr_state_reg)
        plc_pkg::PLC_W_COLLECT: begin
          if (aw_hs) begin
            aw_got_reg    <= 1'b1;
            waddr_reg     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (w_hs) begin
            w_got_reg    <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (do_write) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(waddr_reg) ? plc_pkg::RESP_OKAY
                                              : plc_pkg::RESP_SLVERR;
            wr_state_reg <= plc_pkg::PLC_W_RESP;
          end
        end
        plc_pkg::PLC_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            wr_state_reg  <= plc_pkg::PLC_W_COLLECT;
          end
        end
        default: wr_state_reg <= plc_pkg::PLC_W_COLLECT;
      endcase
    end
  end

  // Configuration stores; a write takes effect on the next cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= plc_pkg::CTRL_RST;
      sel_reg    <= plc_pkg::SEL_RST;
      gate_reg   <= plc_pkg::GATE_RST;
      gpol_reg   <= plc_pkg::GPOL_RST;
      swbits_reg <= plc_pkg::SWBITS_RST;
    end else if (clock_en && do_write) begin
      case (waddr_reg)
        plc_pkg::OFS_CTRL:
          ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
        plc_pkg::OFS_SEL:
          sel_reg <= merge(sel_reg, wdata_reg, wstrb_reg);
        plc_pkg::OFS_GATE:
          gate_reg <= merge(gate_reg, wdata_reg, wstrb_reg);
        plc_pkg::OFS_GPOL:
          if (wstrb_reg[0]) gpol_reg <= wdata_reg[3:0];
        plc_pkg::OFS_SWBITS:
          if (wstrb_reg[0]) swbits_reg <= wdata_reg[3:0];
        default: ;
      endcase
    end
  end

  // Read side: one cycle from address to data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_reg  <= plc_pkg::PLC_R_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= plc_pkg::RESP_OKAY;
    end else if (clock_en) begin
      case (rd_state_reg)
        plc_pkg::PLC_R_IDLE: begin
          if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr) ? plc_pkg::RESP_OKAY
                                                  : plc_pkg::RESP_SLVERR;
            rd_state_reg  <= plc_pkg::PLC_R_DATA;
            case (s_axi_araddr)
              plc_pkg::OFS_CTRL:   s_axi_rdata <= ctrl_reg;
              plc_pkg::OFS_SEL:    s_axi_rdata <= sel_reg;
              plc_pkg::OFS_GATE:   s_axi_rdata <= gate_reg;
              plc_pkg::OFS_GPOL:   s_axi_rdata <= {28'h0, gpol_reg};
              plc_pkg::OFS_SWBITS: s_axi_rdata <= {28'h0, swbits_reg};
              // Snapshot at the address handshake, not at the data beat
              plc_pkg::OFS_STATUS: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rdata[plc_pkg::STAT_OUT_BIT] <= cell_out;
                s_axi_rdata[plc_pkg::STAT_LINES_LSB +: 4] <= lines;
              end
              default: s_axi_rdata <= 32'h0000_0000;
            endcase
          end
        end
        plc_pkg::PLC_R_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state_reg  <= plc_pkg::PLC_R_IDLE;
          end
        end
        default: rd_state_reg <= plc_pkg::PLC_R_IDLE;
      endcase
    end
  end

endmodule : plc_top

/* dv/plc_pool_model.sv */
`timescale 1ns/1ps
// Far side of the cell: pins, peripherals and a free clock
module plc_pool_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [30:0] levels,
  output logic      [31:0] pool_in
);
  logic tick_reg;

  // Halved clock stands in for an internal oscillator source
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
    end
  end

  // Top slot is the clock, the rest pins and peripherals
  assign pool_in = {tick_reg, levels};
endmodule : plc_pool_model

/* dv/plc_top_properties.sv */
`timescale 1ns/1ps
// Bus and output timing watcher for the logic cell
module plc_top_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cell_out,
  input wire logic pin_out,
  input wire logic out_rise,
  input wire logic out_fall
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Answers stand until the master takes them
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  aw_close_a: assert property (
    s_axi_awvalid && s_axi_awready && clock_en |=> !s_axi_awready)
    else $error("address still open");
  // Fixed write latency, so software sees the new logic soon
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && clock_en ##1 clock_en |-> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready && clock_en |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  pin_copy_a: assert property (pin_out == cell_out)
    else $error("pin differs from output");
  // Frozen cycles are skipped: the pulse flops hold then
  rise_mark_a: assert property ($past(clock_en) |->
    out_rise == (cell_out && !$past(cell_out)))
    else $error("rise pulse wrong");
  fall_mark_a: assert property ($past(clock_en) |->
    out_fall == (!cell_out && $past(cell_out)))
    else $error("fall pulse wrong");

  wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_seen_c: cover property (s_axi_rvalid && s_axi_rready);
  rise_seen_c: cover property (out_rise ##1 out_fall);
endmodule : plc_top_props

bind plc_top plc_top_props u_plc_top_props (.clock, .reset_n, .clock_en,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .cell_out, .pin_out, .out_rise, .out_fall);

/* dv/plc_top_bench.sv */
`timescale 1ns/1ps
module plc_top_bench;
  logic        clock, reset_n, clock_en, cell_out, pin_out, pin_oe;
  logic        out_rise, out_fall, s_axi_rvalid, s_axi_rready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, gb;
  logic [31:0] s_axi_wdata, s_axi_rdata, pool_in, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [30:0] levels;
  int          miscompares = 0;
  int          n_checks = 0;
  int          ups, downs;
  // Stateful steps: {function, expected output, line levels}
  localparam logic [7:0] SEQ [37] = '{8'h64, 8'h71, 8'h70, 8'h68, 8'h75,
    8'h70, 8'h84, 8'h80, 8'h93, 8'h92, 8'h90, 8'h81, 8'h98, 8'h8c, 8'ha4,
    8'ha0, 8'ha2, 8'hb3, 8'hb1, 8'hb0, 8'ha5, 8'hc4, 8'hc0, 8'hd3, 8'hd2,
    8'hcb, 8'hca, 8'hdb, 8'hd8, 8'hc9, 8'he4, 8'hf3, 8'he1, 8'he0, 8'he2,
    8'hf8, 8'hf0};

  plc_pool_model u_plc_pool_model (.clock, .reset_n, .levels, .pool_in);
  plc_top u_plc_top (.clock, .reset_n, .clock_en, .pool_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cell_out,
    .pin_out, .pin_oe, .out_rise, .out_fall);

  // Free-running 40 MHz clock
  always #12.5 clock = ~clock;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic hang();
    miscompares++;
    $display("[ERR] handshake expected answer seen timeout");
    final_report();
  endtask : hang

  // Each channel drops its valid at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit dn = 0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        dn = 1;
      end
    end
    if (!dn) hang();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit dn = 0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        dn = 1;
      end
    end
    if (!dn) hang();
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    check("bresp", 32'(rsp), 32'(plc_pkg::RESP_OKAY));
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rdv, rsp);
    check("rdata", rdv, e);
    check("rresp", 32'(rsp), 32'(plc_pkg::RESP_OKAY));
  endtask : rd_chk

  // Output flop lands two edges after the write answer
  task automatic out_is(input logic e);
    repeat (2) @(posedge clock);
    check("cell_out", 32'(cell_out), 32'(e));
  endtask : out_is

  function automatic logic comb(input int m, input logic [3:0] l);
    case (m)
      0: return (l[0] & l[1]) | (l[2] & l[3]);
      1: return (l[0] | l[1]) ^ (l[2] | l[3]);
      default: return &l;
    endcase
  endfunction : comb

  initial begin
    {clock, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, levels} = '0;
    s_axi_wstrb = 4'hf;
    clock_en = 1'b1;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
    check("pin_oe idle", 32'(pin_oe), 32'h0);
    axi_rd(8'h18, rdv, rsp);
    check("gap rresp", 32'(rsp), 32'(plc_pkg::RESP_SLVERR));
    check("gap rdata", rdv, 32'h0);
    axi_wr(8'h1c, 32'hffff_ffff, rsp);
    check("gap bresp", 32'(rsp), 32'(plc_pkg::RESP_SLVERR));
    $display("test reset and map done");
    // Gates with nothing enabled give their invert bit
    wr(plc_pkg::OFS_CTRL, 32'h0000_0105);
    wr(plc_pkg::OFS_GPOL, 32'hf);
    out_is(1'b1);
    check("pin_oe", 32'(pin_oe), 32'h1);
    rd_chk(plc_pkg::OFS_STATUS, 32'hf1);
    wr(plc_pkg::OFS_GPOL, 32'h0);
    out_is(1'b0);
    $display("test constant gates done");
    // Mux 0 walks the pool, gate 0 takes it true or inverted
    wr(plc_pkg::OFS_GPOL, 32'he);
    for (int k = 0; k < 31; k += 3) begin
      levels <= 31'h2a5a_c3c1 ^ {31{k[0]}};
      gb = k[1] ? 8'h02 : 8'h01;
      wr(plc_pkg::OFS_SEL, 32'hc3a5_e000 | k);
      rd_chk(plc_pkg::OFS_SEL, 32'hc3a5_e000 | k);
      wr(plc_pkg::OFS_GATE, {24'h0, gb});
      out_is(levels[k] ^ gb[1]);
    end
    levels <= '0;
    wr(plc_pkg::OFS_SEL, 32'h7);
    wr(plc_pkg::OFS_GATE, 32'h1);
    wr(plc_pkg::OFS_SWBITS, 32'h1);
    out_is(1'b1);
    wr(plc_pkg::OFS_SWBITS, 32'h0);
    out_is(1'b0);
    // Every mux on its own pool bit, every gate with its own enable mix
    levels <= 31'h4000_0202;
    wr(plc_pkg::OFS_SEL, 32'h1e09_0201);
    wr(plc_pkg::OFS_GATE, 32'h0440_9009);
    rd_chk(plc_pkg::OFS_STATUS, 32'hb0);
    wr(plc_pkg::OFS_GPOL, 32'h9);
    rd_chk(plc_pkg::OFS_STATUS, 32'hc0);
    $display("test selection and gating done");
    wr(plc_pkg::OFS_GATE, 32'h0);
    for (int m = 0; m < 3; m++) begin
      for (int v = 0; v < 32; v++) begin
        wr(plc_pkg::OFS_CTRL, {23'h0, 1'b1, v[4], 3'h0, 3'(m), 1'b1});
        wr(plc_pkg::OFS_GPOL, {28'h0, v[3:0]});
        out_is(comb(m, v[3:0]) ^ v[4]);
      end
    end
    $display("test combinational options done");
    foreach (SEQ[i]) begin
      if (i == 0 || SEQ[i][7:5] != SEQ[i - 1][7:5]) begin
        wr(plc_pkg::OFS_CTRL, {23'h0, 1'b1, 4'h0, SEQ[i][7:5], 1'b1});
      end
      wr(plc_pkg::OFS_GPOL, {28'h0, SEQ[i][3:0]});
      out_is(SEQ[i][4]);
    end
    $display("test stateful options done");
    // Toggling pool clock: output follows every cycle
    wr(plc_pkg::OFS_SEL, 32'h1f);
    wr(plc_pkg::OFS_GATE, 32'h1);
    wr(plc_pkg::OFS_GPOL, 32'he);
    wr(plc_pkg::OFS_CTRL, 32'h0000_0105);
    repeat (2) @(posedge clock);
    {ups, downs} = '0;
    repeat (8) begin
      @(posedge clock);
      ups += int'(out_rise);
      downs += int'(out_fall);
    end
    check("rises", 32'(ups), 32'h4);
    check("falls", 32'(downs), 32'h4);
    clock_en <= 1'b0;
    repeat (2) @(posedge clock);
    gb = {7'h0, cell_out};
    repeat (4) begin
      @(posedge clock);
      check("frozen", 32'(cell_out), 32'(gb));
    end
    clock_en <= 1'b1;
    $display("test speed and freeze done");
    final_report();
  end
endmodule : plc_top_bench
